// [rtl/boost_seq_defs.svh]
`ifndef BOOST_SEQ_DEFS_SVH
`define BOOST_SEQ_DEFS_SVH

// system clock rate
`define CLK_FREQ_MHZ           25

// sequence times in microseconds
`define T_PRECHARGE_STEP_US    750
`define T_PRECHARGE_MAX_US     1500
`define T_RESTART_WAIT_US      1000
`define T_FAULT_PULSE_US       1

// derived cycle counts
`define PRECHARGE_STEP_CYC     (`T_PRECHARGE_STEP_US * `CLK_FREQ_MHZ)
`define PRECHARGE_MAX_CYC      (`T_PRECHARGE_MAX_US * `CLK_FREQ_MHZ)
`define RESTART_WAIT_CYC       (`T_RESTART_WAIT_US * `CLK_FREQ_MHZ)
`define FAULT_PULSE_CYC        (`T_FAULT_PULSE_US * `CLK_FREQ_MHZ)

// register offsets
`define REG_CTRL_ADDR          4'h0
`define REG_STATUS_ADDR        4'h1
`define REG_MODE_ADDR          4'h2

// control fields and reset value
`define CTRL_FAULT_PULSE_BIT   0
`define CTRL_NORMAL_ILIM_BIT   1
`define CTRL_RESET             8'h00

`endif

// [rtl/boost_seq_pkg.sv]
package boost_seq_pkg;

    // operating mode, coded as {en, bypass_request_n}
    typedef enum logic [1:0] {
        MODE_LOWIQ_PT     = 2'b00,
        MODE_SHUTDOWN_MIN = 2'b01,
        MODE_FORCED_PT    = 2'b10,
        MODE_AUTO         = 2'b11
    } op_mode_t;

    // sequencer states
    typedef enum logic [2:0] {
        ST_OFF         = 3'b000,
        ST_PRECHARGE   = 3'b001,
        ST_BOOST_START = 3'b010,
        ST_RUN         = 3'b011,
        ST_FAULT_WAIT  = 3'b100,
        ST_DISCHARGE   = 3'b101,
        ST_SHUTDOWN    = 3'b110
    } seq_state_t;

    // comparator indications from the analog side
    typedef struct packed {
        logic out_ge_in;
        logic out_at_preset;
        logic out_below_reg10;
        logic out_below_600mv;
        logic precharge_dropout;
        logic bypass_overcurrent;
        logic valley_over_limit;
        logic temp_above_110;
        logic temp_below_100;
        logic temp_above_115;
        logic temp_above_160;
        logic temp_below_tsd_hyst;
        logic vin_below_uvlo;
        logic vin_above_uvlo_hyst;
    } sense_t;

    // power stage controls
    typedef struct packed {
        logic precharge_on;
        logic precharge_high;
        logic precharge_reduced;
        logic boost_on;
        logic boost_ilim_reduced;
        logic delay_on_time;
        logic bypass_on;
        logic forced_pt;
        logic lowiq_pt;
        logic min_out_shutdown;
        logic discharge_on;
        logic load_connect;
    } stage_t;

endpackage : boost_seq_pkg

// [rtl/phase_timer.sv]
`timescale 1ns/1ps
module phase_timer
    import boost_seq_pkg::*;
#(
    parameter int TIMER_W = 16
)(
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               resetn,
    // control
    input  wire logic               clear,
    // elapsed cycles in the current phase
    output logic [TIMER_W-1:0]      count
);

    // counts up, saturating, restarts on clear
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || clear)
            count <= '0;
        else if (count != '1)
            count <= count + 1'b1;
    end

endmodule : phase_timer

// [rtl/mode_decoder.sv]
`timescale 1ns/1ps
module mode_decoder
    import boost_seq_pkg::*;
(
    // clock and reset
    input  wire logic    clk_sys,
    input  wire logic    resetn,
    // mode pins
    input  wire logic    en,
    input  wire logic    bypass_request_n,
    // decoded mode
    output op_mode_t     mode
);

    // pins sampled together; a skewed auto to low-iq change would pass through
    // the shutdown or the forced pass-through code for a cycle
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            mode <= MODE_AUTO;
        else
            mode <= op_mode_t'({en, bypass_request_n});
    end

endmodule : mode_decoder

// [rtl/boost_seq.sv]
`timescale 1ns/1ps
`include "boost_seq_defs.svh"
module boost_seq
    import boost_seq_pkg::*;
#(
    parameter int PRECHARGE_STEP_CYC = `PRECHARGE_STEP_CYC,
    parameter int PRECHARGE_MAX_CYC  = `PRECHARGE_MAX_CYC,
    parameter int RESTART_WAIT_CYC   = `RESTART_WAIT_CYC,
    parameter int FAULT_PULSE_CYC    = `FAULT_PULSE_CYC,
    parameter int TIMER_W            = 16
)(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // mode pins
    input  wire logic        en,
    input  wire logic        bypass_request_n,
    // output reset / fault pin
    input  wire logic        output_reset_fault_n_in,
    output logic             output_reset_fault_n_out,
    output logic             output_reset_fault_n_oe,
    // analog comparators and power stage
    input  wire sense_t      sense,
    output stage_t           stage,
    // status pins
    output logic             power_good,
    output logic             serial_if_enable,
    // register port
    input  wire logic [3:0]  addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic [7:0]       rd_data
);

    localparam logic [TIMER_W-1:0] STEP_M1 =
        TIMER_W'(PRECHARGE_STEP_CYC - 1);
    localparam logic [TIMER_W-1:0] MAX_M1 =
        TIMER_W'(PRECHARGE_MAX_CYC - 1);
    localparam logic [TIMER_W-1:0] WAIT_M1 =
        TIMER_W'(RESTART_WAIT_CYC - 1);
    localparam logic [7:0] PULSE_LEN = 8'(FAULT_PULSE_CYC);

    // refuse counts the counters cannot hold
    if (PRECHARGE_STEP_CYC < 1 ||
        PRECHARGE_STEP_CYC >= PRECHARGE_MAX_CYC ||
        PRECHARGE_MAX_CYC >= (1 << TIMER_W) ||
        RESTART_WAIT_CYC < 1 ||
        RESTART_WAIT_CYC >= (1 << TIMER_W) ||
        FAULT_PULSE_CYC < 1 || FAULT_PULSE_CYC > 255)
    begin : g_bad_params
        $error("boost_seq: timing parameters out of range");
    end

    seq_state_t         state_reg;
    seq_state_t         state_next;
    op_mode_t           mode;
    logic [TIMER_W-1:0] phase_cnt;
    logic [7:0]         ctrl_reg;
    logic [7:0]         pulse_cnt_reg;
    logic               uvlo_reg;
    logic               tsd_reg;
    logic               fold_reg;
    logic               warm_reg;
    logic               pin_prev_reg;
    logic               reset_edge;
    logic               fault_now;
    logic               active_mode;
    stage_t             stage_next;
    logic               pg_next;

    // mode pins to operating mode
    mode_decoder u_mode (
        .clk_sys          (clk_sys),
        .resetn           (resetn),
        .en               (en),
        .bypass_request_n (bypass_request_n),
        .mode             (mode)
    );

    // elapsed time in the current state
    phase_timer #(.TIMER_W(TIMER_W)) u_timer (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .clear   (state_next != state_reg),
        .count   (phase_cnt)
    );

    // undervoltage lockout with hysteresis, starts locked
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            uvlo_reg <= 1'b1;
        else if (sense.vin_below_uvlo)
            uvlo_reg <= 1'b1;
        else if (sense.vin_above_uvlo_hyst)
            uvlo_reg <= 1'b0;
    end

    // thermal shutdown latch, set wins
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            tsd_reg <= 1'b0;
        else if (sense.temp_above_160)
            tsd_reg <= 1'b1;
        else if (sense.temp_below_tsd_hyst)
            tsd_reg <= 1'b0;
    end

    // pre-charge current fold-back while hot
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            fold_reg <= 1'b0;
        else if (state_reg == ST_PRECHARGE && sense.temp_above_110)
            fold_reg <= 1'b1;
        else if (sense.temp_below_100)
            fold_reg <= 1'b0;
    end

    // early heat warning for power-good
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            warm_reg <= 1'b0;
        else if (sense.temp_above_115)
            warm_reg <= 1'b1;
        else if (sense.temp_below_100)
            warm_reg <= 1'b0;
    end

    // falling edge on the reset pin, ignored while we pull it
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            pin_prev_reg <= 1'b1;
        else
            pin_prev_reg <= output_reset_fault_n_in;
    end

    assign reset_edge = pin_prev_reg && !output_reset_fault_n_in &&
                        !output_reset_fault_n_oe;

    assign active_mode = (mode == MODE_AUTO) || (mode == MODE_FORCED_PT);

    // fault causes
    always_comb
    begin
        fault_now = tsd_reg;
        if (state_reg == ST_PRECHARGE &&
            (sense.precharge_dropout ||
             (phase_cnt >= MAX_M1 && !sense.out_ge_in)))
            fault_now = 1'b1;
        if (state_reg == ST_BOOST_START && phase_cnt >= MAX_M1 &&
            !sense.out_at_preset)
            fault_now = 1'b1;
        if (state_reg == ST_RUN && sense.bypass_overcurrent)
            fault_now = 1'b1;
    end

    // next state
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_OFF:
                if (active_mode)
                    state_next = ST_PRECHARGE;
                else
                    state_next = ST_SHUTDOWN;
            ST_PRECHARGE:
                if (sense.out_ge_in)
                    state_next = (mode == MODE_AUTO) ? ST_BOOST_START
                                                     : ST_RUN;
            ST_BOOST_START:
                if (sense.out_at_preset)
                    state_next = ST_RUN;
            ST_RUN:
                if (!active_mode)
                    state_next = ST_SHUTDOWN;
            ST_FAULT_WAIT:
                if (phase_cnt >= WAIT_M1 && !tsd_reg)
                    state_next = ST_OFF;
            ST_DISCHARGE:
                if (sense.out_below_600mv)
                    state_next = ST_OFF;
            ST_SHUTDOWN:
                if (active_mode)
                    state_next = ST_PRECHARGE;
            default:
                state_next = ST_OFF;
        endcase
        if ((state_reg == ST_PRECHARGE || state_reg == ST_BOOST_START ||
             state_reg == ST_RUN) && reset_edge)
            state_next = ST_DISCHARGE;
        if (fault_now && state_reg != ST_OFF &&
            state_reg != ST_SHUTDOWN)
            state_next = ST_FAULT_WAIT;
        if (uvlo_reg)
            state_next = ST_OFF;
    end

    // state register
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            state_reg <= ST_OFF;
        else
            state_reg <= state_next;
    end

    // power stage settings for the coming state
    always_comb
    begin
        stage_next = '0;
        unique case (state_next)
            ST_PRECHARGE:
            begin
                stage_next.precharge_on      = 1'b1;
                stage_next.precharge_high    =
                    state_reg == ST_PRECHARGE &&
                    phase_cnt >= STEP_M1;
                stage_next.precharge_reduced = fold_reg;
                stage_next.load_connect      = 1'b1;
            end
            ST_BOOST_START:
            begin
                stage_next.boost_on           = 1'b1;
                stage_next.boost_ilim_reduced =
                    !ctrl_reg[`CTRL_NORMAL_ILIM_BIT];
                stage_next.delay_on_time      =
                    sense.valley_over_limit;
                stage_next.load_connect       = 1'b1;
            end
            ST_RUN:
            begin
                stage_next.load_connect = 1'b1;
                if (mode == MODE_FORCED_PT)
                begin
                    stage_next.forced_pt = 1'b1;
                    stage_next.bypass_on = 1'b1;
                end
                else
                begin
                    stage_next.boost_on      = 1'b1;
                    stage_next.delay_on_time =
                        sense.valley_over_limit;
                end
            end
            ST_SHUTDOWN:
                if (mode == MODE_LOWIQ_PT)
                begin
                    stage_next.lowiq_pt  = 1'b1;
                    stage_next.bypass_on = 1'b1;
                end
                else
                    stage_next.min_out_shutdown = 1'b1;
            ST_DISCHARGE:
                stage_next.discharge_on = 1'b1;
            default:
                stage_next = '0;
        endcase
    end

    // power stage register
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            stage <= '0;
        else
            stage <= stage_next;
    end

    // power-good for the coming state
    always_comb
    begin
        pg_next = 1'b0;
        if (state_next == ST_SHUTDOWN)
            pg_next = 1'b1;
        else if (state_next == ST_RUN)
            pg_next = (mode == MODE_FORCED_PT) ||
                      !(sense.out_below_reg10 || warm_reg);
    end

    // power-good register
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            power_good <= 1'b0;
        else
            power_good <= pg_next;
    end

    // serial interface follows the lockout
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            serial_if_enable <= 1'b0;
        else
            serial_if_enable <= !uvlo_reg;
    end

    // fault pulse length counter
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            pulse_cnt_reg <= 8'h00;
        else if (state_next == ST_FAULT_WAIT &&
                 state_reg != ST_FAULT_WAIT &&
                 ctrl_reg[`CTRL_FAULT_PULSE_BIT])
            pulse_cnt_reg <= PULSE_LEN;
        else if (pulse_cnt_reg != 8'h00)
            pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
    end

    // open-drain pin: drive low only while the pulse runs
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            output_reset_fault_n_oe  <= 1'b0;
            output_reset_fault_n_out <= 1'b0;
        end
        else
        begin
            output_reset_fault_n_oe  <= (state_next == ST_FAULT_WAIT &&
                state_reg != ST_FAULT_WAIT &&
                ctrl_reg[`CTRL_FAULT_PULSE_BIT]) ||
                (pulse_cnt_reg > 8'h01);
            output_reset_fault_n_out <= 1'b0;
        end
    end

    // control register writes
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            ctrl_reg <= `CTRL_RESET;
        else if (wr_en && addr == `REG_CTRL_ADDR)
            ctrl_reg <= wr_data;
    end

    // read data, valid the cycle after the strobe only
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || !rd_en)
            rd_data <= 8'h00;
        else
            unique case (addr)
                `REG_CTRL_ADDR:   rd_data <= ctrl_reg;
                `REG_STATUS_ADDR: rd_data <= {power_good, tsd_reg,
                                              warm_reg, uvlo_reg,
                                              fold_reg, state_reg};
                `REG_MODE_ADDR:   rd_data <= {6'h00, mode};
                default:          rd_data <= 8'h00;
            endcase
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_start_precharge: assert property (
        state_reg == ST_OFF && !uvlo_reg && active_mode && !tsd_reg
        |=> state_reg == ST_PRECHARGE && stage.precharge_on)
        else $error("no self start into pre-charge");

    a_precharge_step: assert property (
        state_reg == ST_PRECHARGE && $stable(state_reg) &&
        phase_cnt < STEP_M1 |-> !stage.precharge_high)
        else $error("pre-charge limit raised too early");

    a_precharge_timeout: assert property (
        state_reg == ST_PRECHARGE && phase_cnt == MAX_M1 &&
        !sense.out_ge_in && !uvlo_reg
        |=> state_reg == ST_FAULT_WAIT)
        else $error("pre-charge timeout missed");

    a_fault_quiet: assert property (
        state_reg == ST_FAULT_WAIT |-> stage == '0 && !power_good)
        else $error("stage or power-good active in fault");

    a_fault_wait: assert property (
        $rose(state_reg == ST_FAULT_WAIT) |->
        (state_reg == ST_FAULT_WAIT || uvlo_reg) [*8])
        else $error("fault wait left early");

    a_boost_limit: assert property (
        state_reg == ST_BOOST_START |->
        stage.boost_ilim_reduced == !$past(ctrl_reg[1]))
        else $error("boost start limit wrong");

    a_lowiq_mode: assert property (
        state_reg == ST_SHUTDOWN && $past(mode) == MODE_LOWIQ_PT
        |-> stage.lowiq_pt && stage.bypass_on && power_good)
        else $error("low-iq pass-through not applied");

    a_reset_edge: assert property (
        state_reg == ST_RUN && reset_edge && !fault_now && !uvlo_reg
        |=> state_reg == ST_DISCHARGE && stage.discharge_on)
        else $error("reset edge not followed by discharge");

    a_uvlo_off: assert property (
        uvlo_reg |=> state_reg == ST_OFF && !serial_if_enable)
        else $error("lockout did not stop block");

    a_fault_pulse: assert property (
        $rose(output_reset_fault_n_oe) |->
        $past(ctrl_reg[0]) && state_reg == ST_FAULT_WAIT)
        else $error("fault pulse without fault");

endmodule : boost_seq

// [tb/host_model.sv]
`timescale 1ns/1ps
module host_model
    import boost_seq_pkg::*;
(
    // clock
    input  wire logic     clk_sys,
    // bench commands
    input  wire op_mode_t want_mode,
    input  wire logic     want_reset,
    // pins
    output logic          en,
    output logic          bypass_request_n,
    input  wire logic     fault_oe,
    output logic          pin_level,
    // fault interrupts seen
    output int            fault_edges
);
    logic pull_reg = 1'b0;
    logic last_reg = 1'b1;

    // pins idle at auto mode
    initial
    begin
        en = 1'b1;
        bypass_request_n = 1'b1;
        fault_edges = 0;
    end

    // pull-up holds the line high unless someone pulls low
    assign pin_level = !(fault_oe || pull_reg);

    // both mode pins move on one edge, never skewed
    always @(posedge clk_sys)
    begin
        {en, bypass_request_n} <= want_mode;
        pull_reg               <= want_reset;
    end

    // falling edges act as interrupts
    always @(posedge clk_sys)
    begin
        last_reg <= pin_level;
        if (last_reg && !pin_level)
            fault_edges <= fault_edges + 1;
    end
endmodule : host_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top
    import boost_seq_pkg::*;
;
    localparam int STEP  = 20;
    localparam int MAXC  = 40;
    localparam int WAITC = 30;
    localparam int PULSE = 3;
    logic       clk_sys   = 1'b0;
    logic       resetn    = 1'b0;
    op_mode_t   want_mode = MODE_AUTO;
    logic       want_reset = 1'b0;
    logic       en, bypass_request_n, pin_level, f_out, f_oe;
    sense_t     sense     = '0;
    stage_t     stage;
    logic       power_good, serial_if_enable;
    logic       wr_en     = 1'b0;
    logic       rd_en     = 1'b0;
    logic [3:0] addr      = 4'h0;
    logic [7:0] wr_data   = 8'h00;
    logic [7:0] rd_data, d, r;
    int         fault_edges, n, m, e0;
    int         miscompares = 0;
    int         check_count = 0;
    int         cyc       = 0;
    op_mode_t   tbl[4]    = '{MODE_FORCED_PT, MODE_LOWIQ_PT,
                              MODE_SHUTDOWN_MIN, MODE_AUTO};

    boost_seq #(.PRECHARGE_STEP_CYC(STEP), .PRECHARGE_MAX_CYC(MAXC),
        .RESTART_WAIT_CYC(WAITC), .FAULT_PULSE_CYC(PULSE)) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .en(en),
        .bypass_request_n(bypass_request_n),
        .output_reset_fault_n_in(pin_level),
        .output_reset_fault_n_out(f_out),
        .output_reset_fault_n_oe(f_oe), .sense(sense), .stage(stage),
        .power_good(power_good), .serial_if_enable(serial_if_enable),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data));

    host_model host_u (
        .clk_sys(clk_sys), .want_mode(want_mode), .want_reset(want_reset),
        .en(en), .bypass_request_n(bypass_request_n), .fault_oe(f_oe),
        .pin_level(pin_level), .fault_edges(fault_edges));

    // clock, 40 ns period
    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // hang guard
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : step

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= v;
        @(posedge clk_sys);
        wr_en   <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask : rd

    // poll the state field of the status register
    task automatic wait_st(input seq_state_t s);
        n = 0;
        do
        begin
            rd(4'h1);
            n++;
        end while (d[2:0] !== s && n < 200);
        chk(d[2:0], s);
    endtask : wait_st

    // cycles until the fault pin pulls low (n), then its width (m)
    task automatic fault_pulse();
        n = 0;
        m = 0;
        while (f_oe !== 1'b1 && n < 200)
        begin
            step(1);
            n++;
        end
        while (f_oe === 1'b1 && m < 60)
        begin
            step(1);
            m++;
        end
    endtask : fault_pulse

    function automatic logic [7:0] mode_byte(op_mode_t x);
        return {6'h00, x};
    endfunction : mode_byte

    function automatic logic mode_bit(op_mode_t x, stage_t s);
        case (x)
            MODE_LOWIQ_PT:     return s.lowiq_pt;
            MODE_SHUTDOWN_MIN: return s.min_out_shutdown;
            MODE_FORCED_PT:    return s.forced_pt;
            default:           return !s.forced_pt;
        endcase
    endfunction : mode_bit

    // main sequence
    initial
    begin
        void'($urandom(32'h06887027));
        step(20);
        resetn <= 1'b1;
        step(2);
        chk(serial_if_enable, 1'b0);
        r = $urandom;
        r[1:0] = 2'b01;
        rd(4'hF);
        chk(d, 8'h00);
        wr(4'h0, r);
        rd(4'h0);
        chk(d, r);
        wr(4'h2, ~r);
        rd(4'h2);
        chk(d, mode_byte(MODE_AUTO));
        $display("registers done");
        sense.vin_above_uvlo_hyst <= 1'b1;
        wait_st(ST_PRECHARGE);
        chk(serial_if_enable, 1'b1);
        chk(stage.precharge_high, 1'b0);
        sense.temp_above_110 <= 1'b1;
        step(3);
        chk(stage.precharge_reduced, 1'b1);
        sense.temp_above_110 <= 1'b0;
        sense.temp_below_100 <= 1'b1;
        step(3);
        chk(stage.precharge_reduced, 1'b0);
        sense.temp_below_100 <= 1'b0;
        step(STEP - 4);
        chk(stage.precharge_high, 1'b1);
        sense.out_ge_in <= 1'b1;
        wait_st(ST_BOOST_START);
        chk(stage.boost_ilim_reduced, 1'b1);
        sense.valley_over_limit <= 1'b1;
        step(3);
        chk(stage.delay_on_time, 1'b1);
        sense.valley_over_limit <= 1'b0;
        sense.out_at_preset <= 1'b1;
        wait_st(ST_RUN);
        chk(power_good, 1'b1);
        sense.out_below_reg10 <= 1'b1;
        step(3);
        chk(power_good, 1'b0);
        sense.out_below_reg10 <= 1'b0;
        sense.temp_above_115 <= 1'b1;
        step(3);
        chk(power_good, 1'b0);
        sense.temp_above_115 <= 1'b0;
        sense.temp_below_100 <= 1'b1;
        step(3);
        chk(power_good, 1'b1);
        sense.temp_below_100 <= 1'b0;
        $display("start-up done");
        e0 = fault_edges;
        sense <= '{bypass_overcurrent: 1'b1, vin_above_uvlo_hyst: 1'b1,
                   default: 1'b0};
        fault_pulse();
        chk(m == PULSE, 1'b1);
        chk(f_out, 1'b0);
        chk(power_good, 1'b0);
        chk(stage.load_connect, 1'b0);
        sense.bypass_overcurrent <= 1'b0;
        while (stage.precharge_on !== 1'b1 && m < 200)
        begin
            step(1);
            m++;
        end
        chk(m >= WAITC && m <= WAITC + 4, 1'b1);
        fault_pulse();
        chk(n >= MAXC - 4 && n <= MAXC + 2, 1'b1);
        chk(fault_edges - e0 == 2, 1'b1);
        sense.out_ge_in     <= 1'b1;
        sense.out_at_preset <= 1'b1;
        wait_st(ST_RUN);
        $display("faults done");
        sense.temp_above_160 <= 1'b1;
        step(3);
        chk({stage.bypass_on, stage.boost_on}, 2'b00);
        chk(power_good, 1'b0);
        sense.temp_above_160 <= 1'b0;
        sense.temp_below_tsd_hyst <= 1'b1;
        wait_st(ST_RUN);
        sense.temp_below_tsd_hyst <= 1'b0;
        want_reset <= 1'b1;
        sense.out_ge_in <= 1'b0;
        step(2);
        want_reset <= 1'b0;
        wait_st(ST_DISCHARGE);
        chk(stage.discharge_on, 1'b1);
        sense.out_below_600mv <= 1'b1;
        wait_st(ST_PRECHARGE);
        sense.out_below_600mv <= 1'b0;
        sense.precharge_dropout <= 1'b1;
        wait_st(ST_FAULT_WAIT);
        sense.precharge_dropout <= 1'b0;
        sense.out_ge_in <= 1'b1;
        wait_st(ST_RUN);
        $display("output reset done");
        foreach (tbl[i])
        begin
            want_mode <= tbl[i];
            step(4 + $urandom_range(0, 3));
            wait_st(tbl[i][1] ? ST_RUN : ST_SHUTDOWN);
            rd(4'h2);
            chk(d, mode_byte(tbl[i]));
            chk(mode_bit(tbl[i], stage), 1'b1);
            chk(power_good, 1'b1);
        end
        $display("modes done");
        sense.vin_below_uvlo <= 1'b1;
        sense.vin_above_uvlo_hyst <= 1'b0;
        step(3);
        chk(serial_if_enable, 1'b0);
        chk(stage, '0);
        sense.vin_below_uvlo <= 1'b0;
        sense.vin_above_uvlo_hyst <= 1'b1;
        wait_st(ST_RUN);
        chk(serial_if_enable, 1'b1);
        $display("lockout done");
        tally_and_finish();
    end
endmodule : tb_top
